// [hw/ped_pkg.sv]
// constants for the performance event detection group: event codes, interlock weights,
// increment widths and penalty figures.
// assumes a core that reports pipeline, cache and branch status once per clock.
//
// Contract
// R1 - code 110001 counts multimedia data reads (sel 0) and read misses (sel 1)
// R2 - floating-point freeze stall: one increment per frozen clock
// R3 - taken-branch event counts each branch actually taken
// R4 - count first decode stage issuing nothing because its buffer is empty
// R5 - count first decode stage issuing one because only one is ready
// R6 - count every flush from a wrongly followed branch, execute and writeback
// R7 - all-flush event counts execute and writeback; companion writeback only
// R8 - writeback-resolved misprediction costs one clock more than execute-resolved
// R9 - multimedia misaligned references on sel 0, read-wait stall clocks on sel 1
// R10 - near returns mispredicted or unpredicted, interrupt returns excluded
// R11 - near returns with any prediction made, interrupt returns excluded
// R12 - multiply interlock clocks, no other stall; two if next clock, one if later
// R13 - count clocks a multimedia store waits in address generation on a producer
// R14 - executed near returns plus exceptions on them and interrupts just before
// R15 - count branch target buffer false entries, not wrong direction guesses
// R16 - count not-taken branches that the branch target buffer predicted taken
// R17 - multimedia clocks stalled on full write buffers, multimedia accesses only
// R18 - stalls on multimedia writes to exclusive or modified lines
// R19 - six-bit code plus selector picks the event; selector names the counter
// R20 - each detector gives a per-clock amount, up to two with both pipes

package ped_pkg;

	localparam int PED_CODE_W = 6;
	localparam int PED_INC_W = 2;
	localparam logic [5:0] PED_EV_MM_READ = 6'h31;
	localparam logic [5:0] PED_EV_FP_BRANCH = 6'h32;
	localparam logic [5:0] PED_EV_STARVE = 6'h33;
	localparam logic [5:0] PED_EV_FLUSH = 6'h35;
	localparam logic [5:0] PED_EV_MM_ALIGN = 6'h36;
	localparam logic [5:0] PED_EV_RETURN_PRED = 6'h37;
	localparam logic [5:0] PED_EV_MM_MUL = 6'h38;
	localparam logic [5:0] PED_EV_RETURN_EXEC = 6'h39;
	localparam logic [5:0] PED_EV_TARGET_FALSE = 6'h3a;
	localparam logic [5:0] PED_EV_MM_WBUF = 6'h3b;
	localparam logic [1:0] PED_INC_ZERO = 2'h0;
	// branch penalty in clocks; writeback adds one over execute
	localparam logic [2:0] PED_PEN_EXEC = 3'h3;
	localparam logic [2:0] PED_PEN_WB = PED_PEN_EXEC + 3'h1;
	// interlock weights by distance from the multiply
	localparam logic [1:0] PED_MUL_NEAR = 2'h2;
	localparam logic [1:0] PED_MUL_FAR = 2'h1;

endpackage

// [hw/ped_detect.sv]
// performance event detector for codes 49 to 59 feeding two counters.
// assumes status inputs are synchronous to core_clk and valid every clock;
// each counter presents a code and receives a registered increment amount.
`timescale 1ns/100ps

module ped_detect
	import ped_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// event selection, one per counter (counter 0 and counter 1)
	input wire logic [5:0] cnt0_code,
	input wire logic [5:0] cnt1_code,
	// multimedia memory traffic, u and v pipes in bits 0 and 1
	input wire logic [1:0] mm_data_read,
	input wire logic [1:0] mm_read_miss,
	input wire logic [1:0] mm_misaligned,
	input wire logic mm_read_wait,
	input wire logic mm_wbuf_full_stall,
	input wire logic [1:0] mm_write_em_stall,
	// pipeline status
	input wire logic fp_freeze,
	input wire logic [1:0] branch_taken,
	input wire logic [1:0] first_decode_stage_ready,
	input wire logic first_decode_stage_starve,
	input wire logic other_stall,
	input wire logic mm_mul_dep_wait,
	input wire logic mm_mul_dist2,
	input wire logic mm_store_dep_wait,
	// branch resolution
	input wire logic flush_exec,
	input wire logic flush_wb,
	input wire logic [1:0] branch_target_buffer_false,
	input wire logic [1:0] branch_target_buffer_nt_as_t,
	// returns
	input wire logic near_return_instruction,
	input wire logic return_predicted,
	input wire logic return_pred_ok,
	input wire logic return_exc_or_int,
	// increments to the counters, and the flush penalty
	output logic [1:0] cnt0_inc,
	output logic [1:0] cnt1_inc,
	output logic [2:0] flush_penalty
);

	// ****************************************
	// helpers
	// ****************************************

	// number of pipes asserting an event, up to two
	function automatic logic [1:0] ped_pair(input logic [1:0] v);
		ped_pair = {1'b0, v[0]} + {1'b0, v[1]}; // see R20
	endfunction

	// one-clock event expressed as an increment
	function automatic logic [1:0] ped_one(input logic v);
		ped_one = {1'b0, v};
	endfunction

	// ****************************************
	// interlock tracking
	// ****************************************

	logic mul_first_r;
	logic mul_first_nxt;
	logic mul_stall;

	// only a pure multiply stall counts; other causes suppress it
	assign mul_stall = mm_mul_dep_wait && !other_stall; // see R12
	// the first clock of a near interlock is remembered for the checks; the decode adds one per stalled clock
	assign mul_first_nxt = mul_stall && !mm_mul_dist2 && !mul_first_r;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mul_first_r <= 1'b0;
		end else begin
			mul_first_r <= mul_first_nxt;
		end
	end

	// ****************************************
	// event decode
	// ****************************************

	// per-variant amounts, selected by code and selector
	function automatic logic [1:0] ped_amount(input logic [5:0] code, input logic sel);
		logic [1:0] a;
		a = PED_INC_ZERO;
		case (code)
			PED_EV_MM_READ: a = sel ? ped_pair(mm_read_miss) : ped_pair(mm_data_read); // see R1
			PED_EV_FP_BRANCH: a = sel ? ped_pair(branch_taken) : ped_one(fp_freeze); // see R2 see R3
			PED_EV_STARVE: begin
				// see R4 see R5
				if (sel) begin
					a = ped_one(first_decode_stage_starve && (ped_pair(first_decode_stage_ready) == 2'h1));
				end else begin
					a = ped_one(first_decode_stage_starve && (first_decode_stage_ready == 2'h0));
				end
			end
			// all flushes from execute or writeback vs writeback only
			PED_EV_FLUSH: a = sel ? ped_one(flush_wb) : ped_one(flush_exec || flush_wb); // see R6 see R7
			PED_EV_MM_ALIGN: a = sel ? ped_one(mm_read_wait) : ped_pair(mm_misaligned); // see R9
			PED_EV_RETURN_PRED: begin
				// see R10 see R11
				if (sel) begin
					a = ped_one(near_return_instruction && return_predicted);
				end else begin
					a = ped_one(near_return_instruction && !(return_predicted && return_pred_ok));
				end
			end
			PED_EV_MM_MUL: begin
				// see R12 see R13
				if (sel) begin
					a = ped_one(mm_store_dep_wait);
				end else if (mul_stall) begin
					a = PED_MUL_FAR;
				end
			end
			PED_EV_RETURN_EXEC: begin
				// see R14
				a = sel ? PED_INC_ZERO : ped_one(near_return_instruction || return_exc_or_int);
			end
			PED_EV_TARGET_FALSE: begin
				// see R15 see R16
				if (sel) begin
					a = ped_pair(branch_target_buffer_nt_as_t);
				end else begin
					a = ped_pair(branch_target_buffer_false);
				end
			end
			PED_EV_MM_WBUF: a = sel ? ped_pair(mm_write_em_stall) : ped_one(mm_wbuf_full_stall); // see R17 see R18
			default: a = PED_INC_ZERO;
		endcase
		ped_amount = a;
	endfunction

	// ****************************************
	// counter outputs
	// ****************************************

	// counter 0 sees selector 0 variants, counter 1 sees selector 1
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cnt0_inc <= PED_INC_ZERO;
			cnt1_inc <= PED_INC_ZERO;
		end else begin
			cnt0_inc <= ped_amount(cnt0_code, 1'b0); // see R19
			cnt1_inc <= ped_amount(cnt1_code, 1'b1); // see R19
		end
	end

	// penalty of the flush now resolving, one more for writeback
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			flush_penalty <= 3'h0;
		end else if (flush_wb) begin
			flush_penalty <= PED_PEN_WB; // see R8
		end else if (flush_exec) begin
			flush_penalty <= PED_PEN_EXEC; // see R8
		end else begin
			flush_penalty <= 3'h0;
		end
	end

	// ****************************************
	// checks
	// ****************************************

	fp_stall_inc_a: assert property (@(posedge core_clk) disable iff (reset) // see R2
		(cnt0_code == PED_EV_FP_BRANCH) |=> (cnt0_inc == {1'b0, $past(fp_freeze)}))
		else $error("fp stall increment wrong");

	taken_pair_a: assert property (@(posedge core_clk) disable iff (reset) // see R3
		(cnt1_code == PED_EV_FP_BRANCH && branch_taken == 2'h3) |=> (cnt1_inc == 2'h2))
		else $error("two taken branches not counted as two");

	wb_flush_a: assert property (@(posedge core_clk) disable iff (reset) // see R7
		(cnt1_code == PED_EV_FLUSH && flush_exec && !flush_wb) |=> (cnt1_inc == 2'h0))
		else $error("execute flush counted as writeback");

	all_flush_a: assert property (@(posedge core_clk) disable iff (reset) // see R6
		(cnt0_code == PED_EV_FLUSH && flush_wb) |=> (cnt0_inc == 2'h1))
		else $error("writeback flush missed by all-flush event");

	wb_penalty_a: assert property (@(posedge core_clk) disable iff (reset) // see R8
		flush_wb |=> (flush_penalty == PED_PEN_EXEC + 3'h1))
		else $error("writeback penalty not one more");

	nonreturn_excl_a: assert property (@(posedge core_clk) disable iff (reset) // see R11
		(cnt1_code == PED_EV_RETURN_PRED && !near_return_instruction) |=> (cnt1_inc == 2'h0))
		else $error("non-return counted as predicted return");

	mul_near_a: assert property (@(posedge core_clk) disable iff (reset) // see R12
		(cnt0_code == PED_EV_MM_MUL && mul_stall && !mm_mul_dist2 && !mul_first_r)
		##1 (cnt0_code == PED_EV_MM_MUL && mul_stall) |=> (cnt0_inc == 2'h1))
		else $error("near interlock not counted twice");

	mul_other_a: assert property (@(posedge core_clk) disable iff (reset) // see R12
		(cnt0_code == PED_EV_MM_MUL && other_stall) |=> (cnt0_inc == 2'h0))
		else $error("interlock counted under another stall");

	starve_empty_a: assert property (@(posedge core_clk) disable iff (reset) // see R4
		(cnt0_code == PED_EV_STARVE && first_decode_stage_starve
		&& first_decode_stage_ready == 2'h0) |=> (cnt0_inc == 2'h1))
		else $error("empty-buffer starvation missed");

	// ****************************************
	// per-variant increment checks, plus the execute penalty and unknown codes
	// ****************************************

	mm_read_pair_a: assert property (@(posedge core_clk) disable iff (reset) // see R1
		(cnt0_code == PED_EV_MM_READ && mm_data_read == 2'h3) |=> (cnt0_inc == 2'h2))
		else $error("two multimedia reads not counted as two");

	mm_miss_one_a: assert property (@(posedge core_clk) disable iff (reset) // see R1
		(cnt1_code == PED_EV_MM_READ && mm_read_miss == 2'h1) |=> (cnt1_inc == 2'h1))
		else $error("multimedia read miss not counted");

	fp_sel_one_a: assert property (@(posedge core_clk) disable iff (reset) // see R19
		(cnt1_code == PED_EV_FP_BRANCH && branch_taken == 2'h0) |=> (cnt1_inc == 2'h0))
		else $error("freeze seen by the taken-branch counter");

	starve_one_a: assert property (@(posedge core_clk) disable iff (reset) // see R5
		(cnt1_code == PED_EV_STARVE && first_decode_stage_starve
		&& first_decode_stage_ready == 2'h1) |=> (cnt1_inc == 2'h1))
		else $error("single-issue starvation missed");

	starve_full_a: assert property (@(posedge core_clk) disable iff (reset) // see R5
		(cnt1_code == PED_EV_STARVE && first_decode_stage_ready == 2'h3) |=> (cnt1_inc == 2'h0))
		else $error("two ready counted as single issue");

	exec_flush_a: assert property (@(posedge core_clk) disable iff (reset) // see R6
		(cnt0_code == PED_EV_FLUSH && flush_exec) |=> (cnt0_inc == 2'h1))
		else $error("execute flush missed by all-flush event");

	exec_penalty_a: assert property (@(posedge core_clk) disable iff (reset) // see R8
		(flush_exec && !flush_wb) |=> (flush_penalty == PED_PEN_EXEC))
		else $error("execute penalty wrong");

	mm_align_a: assert property (@(posedge core_clk) disable iff (reset) // see R9
		(cnt0_code == PED_EV_MM_ALIGN && mm_misaligned == 2'h3) |=> (cnt0_inc == 2'h2))
		else $error("misaligned pair not counted as two");

	read_wait_a: assert property (@(posedge core_clk) disable iff (reset) // see R9
		(cnt1_code == PED_EV_MM_ALIGN) |=> (cnt1_inc == {1'b0, $past(mm_read_wait)}))
		else $error("read wait clock miscounted");

	return_miss_a: assert property (@(posedge core_clk) disable iff (reset) // see R10
		(cnt0_code == PED_EV_RETURN_PRED && near_return_instruction && !return_predicted)
		|=> (cnt0_inc == 2'h1))
		else $error("unpredicted return not counted");

	return_hit_a: assert property (@(posedge core_clk) disable iff (reset) // see R10
		(cnt0_code == PED_EV_RETURN_PRED && return_predicted && return_pred_ok)
		|=> (cnt0_inc == 2'h0))
		else $error("correct return counted as wrong");

	return_pred_a: assert property (@(posedge core_clk) disable iff (reset) // see R11
		(cnt1_code == PED_EV_RETURN_PRED && near_return_instruction && return_predicted)
		|=> (cnt1_inc == 2'h1))
		else $error("predicted return not counted");

	mul_total_a: assert property (@(posedge core_clk) disable iff (reset) // see R12
		(cnt0_code == PED_EV_MM_MUL && mul_stall && !mm_mul_dist2 && !mul_first_r)
		##1 (cnt0_code == PED_EV_MM_MUL && mul_stall)
		|=> (({1'b0, cnt0_inc} + {1'b0, $past(cnt0_inc)}) == {1'b0, PED_MUL_NEAR}))
		else $error("near interlock total not two");

	mul_far_a: assert property (@(posedge core_clk) disable iff (reset) // see R12
		(cnt0_code == PED_EV_MM_MUL && mul_stall && mm_mul_dist2) |=> (cnt0_inc == PED_MUL_FAR))
		else $error("far interlock not counted once");

	store_wait_a: assert property (@(posedge core_clk) disable iff (reset) // see R13
		(cnt1_code == PED_EV_MM_MUL) |=> (cnt1_inc == {1'b0, $past(mm_store_dep_wait)}))
		else $error("store wait clock miscounted");

	return_exec_a: assert property (@(posedge core_clk) disable iff (reset) // see R14
		(cnt0_code == PED_EV_RETURN_EXEC && (near_return_instruction || return_exc_or_int))
		|=> (cnt0_inc == 2'h1))
		else $error("executed return not counted");

	return_sel_one_a: assert property (@(posedge core_clk) disable iff (reset) // see R14
		(cnt1_code == PED_EV_RETURN_EXEC) |=> (cnt1_inc == 2'h0))
		else $error("undefined return variant counted");

	target_false_a: assert property (@(posedge core_clk) disable iff (reset) // see R15
		(cnt0_code == PED_EV_TARGET_FALSE && branch_target_buffer_false == 2'h3)
		|=> (cnt0_inc == 2'h2))
		else $error("false entries not counted per pipe");

	target_nt_a: assert property (@(posedge core_clk) disable iff (reset) // see R16
		(cnt1_code == PED_EV_TARGET_FALSE && branch_target_buffer_nt_as_t == 2'h1)
		|=> (cnt1_inc == 2'h1))
		else $error("not-taken predicted taken missed");

	wbuf_full_a: assert property (@(posedge core_clk) disable iff (reset) // see R17
		(cnt0_code == PED_EV_MM_WBUF) |=> (cnt0_inc == {1'b0, $past(mm_wbuf_full_stall)}))
		else $error("write buffer stall clock miscounted");

	em_stall_a: assert property (@(posedge core_clk) disable iff (reset) // see R18
		(cnt1_code == PED_EV_MM_WBUF && mm_write_em_stall == 2'h3) |=> (cnt1_inc == 2'h2))
		else $error("owned-line write stalls not counted per pipe");

	unknown_code_a: assert property (@(posedge core_clk) disable iff (reset) // see R19
		(cnt0_code < PED_EV_MM_READ || cnt0_code == 6'h34) |=> (cnt0_inc == 2'h0))
		else $error("code outside the group counted");

endmodule

// [sim/test_ped_detect.sv]
// self-checking bench for the performance event detector.
// assumes each amount appears one edge after its status is sampled.
`timescale 1ns/100ps

module test_ped_detect import ped_pkg::*;;
	// ************
	// signals
	// ************
	logic core_clk, reset, mm_read_wait, mm_wbuf_full_stall, fp_freeze, other_stall;
	logic first_decode_stage_starve, mm_mul_dep_wait, mm_mul_dist2, mm_store_dep_wait;
	logic flush_exec, flush_wb, near_return_instruction, return_predicted, return_pred_ok;
	logic return_exc_or_int;
	logic [5:0] cnt0_code, cnt1_code;
	logic [1:0] mm_data_read, mm_read_miss, mm_misaligned, mm_write_em_stall, branch_taken;
	logic [1:0] first_decode_stage_ready, branch_target_buffer_false;
	logic [1:0] branch_target_buffer_nt_as_t, cnt0_inc, cnt1_inc;
	logic [2:0] flush_penalty;
	int fail_count, checked, cyc;
	ped_detect dut (.core_clk, .reset, .cnt0_code, .cnt1_code, .mm_data_read, .mm_read_miss,
		.mm_misaligned, .mm_read_wait, .mm_wbuf_full_stall, .mm_write_em_stall, .fp_freeze,
		.branch_taken, .first_decode_stage_ready, .first_decode_stage_starve, .other_stall,
		.mm_mul_dep_wait, .mm_mul_dist2, .mm_store_dep_wait, .flush_exec, .flush_wb,
		.branch_target_buffer_false, .branch_target_buffer_nt_as_t, .near_return_instruction,
		.return_predicted, .return_pred_ok, .return_exc_or_int, .cnt0_inc, .cnt1_inc,
		.flush_penalty);
	// ************
	// helpers
	// ************
	task automatic cmp_inc(string nm, logic [1:0] e, logic [1:0] g);
		checked++;
		if (e !== g) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_pen(logic [2:0] e);
		checked++;
		if (e !== flush_penalty) begin
			fail_count++;
			$display("ERROR flush_penalty expected %h seen %h", e, flush_penalty);
		end
	endtask
	// status is only idled, the codes stay so a test can run several steps on one event
	task automatic clr();
		{mm_read_wait, mm_wbuf_full_stall, fp_freeze, other_stall, first_decode_stage_starve,
			mm_mul_dep_wait, mm_mul_dist2, mm_store_dep_wait, flush_exec, flush_wb,
			near_return_instruction, return_predicted, return_pred_ok, return_exc_or_int,
			mm_data_read,
			mm_read_miss, mm_misaligned, mm_write_em_stall, branch_taken,
			first_decode_stage_ready, branch_target_buffer_false,
			branch_target_buffer_nt_as_t} = '0;
	endtask
	// inputs are set at a falling edge; the answer is read a full clock later
	task automatic look(logic [1:0] e0, logic [1:0] e1);
		@(posedge core_clk);
		@(negedge core_clk);
		cmp_inc("cnt0_inc", e0, cnt0_inc);
		cmp_inc("cnt1_inc", e1, cnt1_inc);
	endtask
	task automatic run(logic [1:0] e0, logic [1:0] e1);
		look(e0, e1);
		clr();
		@(negedge core_clk);
	endtask
	task automatic codes(logic [5:0] a, logic [5:0] b);
		cnt0_code = a;
		cnt1_code = b;
	endtask
	// ************
	// scenarios
	// ************
	task automatic t_mm();
		codes(PED_EV_MM_READ, PED_EV_MM_READ);
		mm_data_read = 2'h3; mm_read_miss = 2'h1; run(2'h2, 2'h1);
		codes(PED_EV_MM_ALIGN, PED_EV_MM_ALIGN);
		mm_misaligned = 2'h2; mm_read_wait = 1'b1; run(2'h1, 2'h1);
		codes(PED_EV_MM_WBUF, PED_EV_MM_WBUF);
		mm_wbuf_full_stall = 1'b1; mm_write_em_stall = 2'h3; run(2'h1, 2'h2);
		$display("test mm_traffic done");
	endtask
	task automatic t_fp_dec();
		codes(PED_EV_FP_BRANCH, PED_EV_FP_BRANCH);
		fp_freeze = 1'b1; run(2'h1, 2'h0);
		branch_taken = 2'h3; run(2'h0, 2'h2);
		codes(PED_EV_STARVE, PED_EV_STARVE);
		first_decode_stage_starve = 1'b1; run(2'h1, 2'h0);
		first_decode_stage_starve = 1'b1; first_decode_stage_ready = 2'h1; run(2'h0, 2'h1);
		codes(6'h34, 6'h34);
		fp_freeze = 1'b1; branch_taken = 2'h3; run(2'h0, 2'h0);
		$display("test pipe_status done");
	endtask
	task automatic t_flush();
		codes(PED_EV_FLUSH, PED_EV_FLUSH);
		flush_exec = 1'b1; look(2'h1, 2'h0);
		cmp_pen(PED_PEN_EXEC);
		clr(); flush_wb = 1'b1; look(2'h1, 2'h1);
		cmp_pen(PED_PEN_EXEC + 3'h1);
		clr(); @(negedge core_clk);
		codes(PED_EV_TARGET_FALSE, PED_EV_TARGET_FALSE);
		branch_target_buffer_false = 2'h3; branch_target_buffer_nt_as_t = 2'h1;
		run(2'h2, 2'h1);
		$display("test branch_flush done");
	endtask
	task automatic t_ret();
		codes(PED_EV_RETURN_PRED, PED_EV_RETURN_PRED);
		near_return_instruction = 1'b1; return_predicted = 1'b1; return_pred_ok = 1'b1;
		run(2'h0, 2'h1);
		near_return_instruction = 1'b1; return_predicted = 1'b1; run(2'h1, 2'h1);
		near_return_instruction = 1'b1; run(2'h1, 2'h0);
		codes(PED_EV_RETURN_EXEC, PED_EV_RETURN_EXEC);
		near_return_instruction = 1'b1; run(2'h1, 2'h0);
		return_exc_or_int = 1'b1; run(2'h1, 2'h0);
		$display("test returns done");
	endtask
	// the near interlock holds the stall on consecutive clocks, so no idle clock between
	task automatic t_mul();
		codes(PED_EV_MM_MUL, PED_EV_MM_MUL);
		mm_mul_dep_wait = 1'b1; look(2'h1, 2'h0);
		look(2'h1, 2'h0);
		mm_mul_dist2 = 1'b1; look(2'h1, 2'h0);
		other_stall = 1'b1; run(2'h0, 2'h0);
		mm_store_dep_wait = 1'b1; run(2'h0, 2'h1);
		$display("test multiply_store done");
	endtask
	// ************
	// run control
	// ************
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// a hang is cut after far more clocks than the whole sequence takes
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			fail_count++;
			end_of_test();
		end
	end
	initial begin
		cyc = 0; fail_count = 0; checked = 0; reset = 1'b1;
		codes(6'h0, 6'h0);
		clr();
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		reset = 1'b0;
		@(negedge core_clk);
		t_mm();
		t_fp_dec();
		t_flush();
		t_ret();
		t_mul();
		end_of_test();
	end
endmodule
